// file: hdl/dsb_sense_builder.sv
// Descriptor sense data builder: AHB-Lite registers and sense byte stream
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module dsb_sense_builder (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             senseValid,
	input  wire logic        senseReady,
	output logic      [7:0]  senseData,
	output logic      [5:0]  senseIndex,
	output logic             senseLast
);

	dsb_fields_if fields ();

	dsb_byte_map u_map (
		.f (fields.map)
	);

	// Bus state
	logic       wrPend_ff;
	logic       rdPend_ff;
	logic [7:0] wrAddr_ff;
	logic [7:0] rdAddr_ff;
	logic [31:0] hrdata_ff;

	// Software registers
	logic        deferred_ff;
	logic        infoValid_ff;
	logic        mismatch_ff;
	logic        progressMode_ff;
	logic [3:0]  senseKey_ff;
	logic [7:0]  asc_ff;
	logic [7:0]  ascq_ff;
	logic [63:0] lba_ff;
	logic [31:0] residue_ff;
	logic [63:0] cmdSpec_ff;
	logic [23:0] keySpec_ff;
	logic [15:0] progress_ff;
	logic [7:0]  partCode_ff;
	logic [15:0] unitErr_ff;
	logic [47:0] phys_ff;
	logic [7:0]  alloc_ff;

	// Stream state
	dsb_pkg::dsb_state_t state_ff;
	dsb_pkg::dsb_state_t nxt_state;
	logic [5:0] idx_ff;
	logic [6:0] len_ff;
	logic [7:0] data_ff;
	logic [6:0] sent_ff;

	logic       addrTaken;
	logic       busy;
	logic       wrEn;
	logic       startReq;
	logic [6:0] allowLen;
	logic [5:0] nxtIdx;
	logic       lastByte;
	logic       accept;

	assign addrTaken = hsel && htrans[1] && hready;
	assign busy      = (state_ff == dsb_pkg::ST_SEND);
	// Fields are frozen while a frame is out, so no frame is torn
	assign wrEn      = wrPend_ff && !busy;
	assign startReq  = wrEn && (wrAddr_ff == dsb_pkg::REG_CTRL) && hwdata[dsb_pkg::CTRL_START];
	assign allowLen  = (alloc_ff > {1'b0, dsb_pkg::SENSE_BYTES}) ? dsb_pkg::SENSE_BYTES
	                                                          : alloc_ff[6:0];
	assign lastByte  = ({1'b0, idx_ff} + 7'h01) == len_ff;
	assign accept    = busy && senseReady;

	assign hreadyout = !rdPend_ff;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	assign senseValid = busy;
	assign senseData  = data_ff;
	assign senseIndex = idx_ff;
	assign senseLast  = busy && lastByte;

	// Register read decode; unmapped words read zero
	function automatic logic [31:0] regRead(input logic [7:0] a);
		unique case (a)
			dsb_pkg::REG_CTRL:     regRead = {27'h0, progressMode_ff, mismatch_ff,
			                                  infoValid_ff, deferred_ff, 1'b0};
			dsb_pkg::REG_KEY:      regRead = {8'h00, ascq_ff, asc_ff, 4'h0, senseKey_ff};
			dsb_pkg::REG_LBA_LO:   regRead = lba_ff[31:0];
			dsb_pkg::REG_LBA_HI:   regRead = lba_ff[63:32];
			dsb_pkg::REG_RESIDUE:  regRead = residue_ff;
			dsb_pkg::REG_CMD_LO:   regRead = cmdSpec_ff[31:0];
			dsb_pkg::REG_CMD_HI:   regRead = cmdSpec_ff[63:32];
			dsb_pkg::REG_KEYSPEC:  regRead = {8'h00, keySpec_ff};
			dsb_pkg::REG_PROGRESS: regRead = {16'h0000, progress_ff};
			dsb_pkg::REG_PART:     regRead = {24'h0, partCode_ff};
			dsb_pkg::REG_UNITERR:  regRead = {16'h0000, unitErr_ff};
			dsb_pkg::REG_PHYS_LO:  regRead = phys_ff[31:0];
			dsb_pkg::REG_PHYS_HI:  regRead = {16'h0000, phys_ff[47:32]};
			dsb_pkg::REG_ALLOC:    regRead = {24'h0, alloc_ff};
			dsb_pkg::REG_STATUS:   regRead = {16'h0000, 1'b0, sent_ff, 7'h00, busy};
			default:               regRead = 32'h0000_0000;
		endcase
	endfunction

	// Bus phases; reads take one wait state so a preceding write is seen
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wrPend_ff <= 1'b0;
			rdPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			rdAddr_ff <= 8'h00;
		end else begin
			wrPend_ff <= addrTaken && hwrite;
			rdPend_ff <= addrTaken && !hwrite;
			if (addrTaken) begin
				wrAddr_ff <= {haddr[7:2], 2'b00};
				rdAddr_ff <= {haddr[7:2], 2'b00};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			hrdata_ff <= dsb_pkg::WORD_RESET;
		end else if (rdPend_ff) begin
			hrdata_ff <= regRead(rdAddr_ff);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			deferred_ff     <= 1'b0;
			infoValid_ff    <= 1'b0;
			mismatch_ff     <= 1'b0;
			progressMode_ff <= 1'b0;
			senseKey_ff     <= 4'h0;
			asc_ff          <= 8'h00;
			ascq_ff         <= 8'h00;
			lba_ff          <= 64'h0;
			residue_ff      <= dsb_pkg::WORD_RESET;
			cmdSpec_ff      <= 64'h0;
			keySpec_ff      <= 24'h0;
			progress_ff     <= 16'h0000;
			partCode_ff     <= 8'h00;
			unitErr_ff      <= 16'h0000;
			phys_ff         <= 48'h0;
			alloc_ff        <= dsb_pkg::ALLOC_RESET;
		end else if (wrEn) begin
			unique case (wrAddr_ff)
				dsb_pkg::REG_CTRL: begin
					deferred_ff     <= hwdata[dsb_pkg::CTRL_DEFERRED];
					infoValid_ff    <= hwdata[dsb_pkg::CTRL_INFO_VAL];
					mismatch_ff     <= hwdata[dsb_pkg::CTRL_MISMATCH];
					progressMode_ff <= hwdata[dsb_pkg::CTRL_PROGRESS];
				end
				dsb_pkg::REG_KEY: begin
					senseKey_ff <= hwdata[3:0];
					asc_ff      <= hwdata[15:8];
					ascq_ff     <= hwdata[23:16];
				end
				dsb_pkg::REG_LBA_LO:   lba_ff[31:0]   <= hwdata;
				dsb_pkg::REG_LBA_HI:   lba_ff[63:32]  <= hwdata;
				dsb_pkg::REG_RESIDUE:  residue_ff     <= hwdata;
				dsb_pkg::REG_CMD_LO:   cmdSpec_ff[31:0]  <= hwdata;
				dsb_pkg::REG_CMD_HI:   cmdSpec_ff[63:32] <= hwdata;
				dsb_pkg::REG_KEYSPEC:  keySpec_ff     <= hwdata[23:0];
				dsb_pkg::REG_PROGRESS: progress_ff    <= hwdata[15:0];
				dsb_pkg::REG_PART:     partCode_ff    <= hwdata[7:0];
				dsb_pkg::REG_UNITERR:  unitErr_ff     <= hwdata[15:0];
				dsb_pkg::REG_PHYS_LO:  phys_ff[31:0]  <= hwdata;
				dsb_pkg::REG_PHYS_HI:  phys_ff[47:32] <= hwdata[15:0];
				dsb_pkg::REG_ALLOC:    alloc_ff       <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// Field selection handed to the byte map
	// Byte 0 loads on the START edge, the same edge on which the new control bits land
	assign fields.responseDeferred    = startReq ? hwdata[dsb_pkg::CTRL_DEFERRED] : deferred_ff;
	assign fields.senseKey            = senseKey_ff;
	assign fields.asc                 = asc_ff;
	assign fields.ascq                = ascq_ff;
	assign fields.infoValid           = infoValid_ff;
	// Residue is held as 32 bits; sign extension keeps negatives correct
	assign fields.infoField           = mismatch_ff ? {{32{residue_ff[31]}}, residue_ff}
	                                                : lba_ff;
	assign fields.cmdSpecific         = cmdSpec_ff;
	assign fields.keySpecificValid    = progressMode_ff | keySpec_ff[23];
	assign fields.keySpecificBits     = progressMode_ff ? 7'h00 : keySpec_ff[22:16];
	assign fields.keySpecificBytes    = progressMode_ff ? progress_ff : keySpec_ff[15:0];
	assign fields.replaceablePartCode = partCode_ff;
	assign fields.lengthMismatchFlag  = mismatch_ff;
	assign fields.unitErrorCode       = unitErr_ff;
	assign fields.physRecord          = phys_ff;
	assign fields.byteIndex           = nxtIdx;

	// Index of the byte to be loaded next
	always_comb begin
		nxtIdx = busy ? (idx_ff + 6'h01) : 6'h00;
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			dsb_pkg::ST_IDLE: if (startReq && (allowLen != 7'h00)) nxt_state = dsb_pkg::ST_SEND;
			dsb_pkg::ST_SEND: if (senseReady && lastByte) nxt_state = dsb_pkg::ST_IDLE;
			default:          nxt_state = dsb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_ff <= dsb_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			idx_ff  <= 6'h00;
			len_ff  <= 7'h00;
			data_ff <= 8'h00;
		end else if (!busy && startReq) begin
			idx_ff  <= 6'h00;
			len_ff  <= allowLen;
			data_ff <= fields.byteOut;
		end else if (accept && !lastByte) begin
			idx_ff  <= nxtIdx;
			data_ff <= fields.byteOut;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sent_ff <= 7'h00;
		end else if (!busy && startReq) begin
			sent_ff <= 7'h00;
		end else if (accept) begin
			sent_ff <= sent_ff + 7'h01;
		end
	end

	a_byte_limit: assert property (@(posedge clock) disable iff (!rst_b)
		senseValid |-> (senseIndex < 6'h3c))
		else $error("sense byte index beyond byte 59");

	a_host_limit: assert property (@(posedge clock) disable iff (!rst_b)
		senseValid |-> ({1'b0, senseIndex} < len_ff) && (len_ff <= {1'b0, alloc_ff[6:0]}
		|| alloc_ff > 8'h3c))
		else $error("sense byte beyond allowed count");

	a_stream_step: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseReady && !senseLast) |=>
		(senseValid && senseIndex == $past(senseIndex) + 6'h01))
		else $error("stream did not advance by one byte");

	a_stream_end: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseReady && senseLast) |=> !senseValid)
		else $error("stream ran past its last byte");

	a_header_bytes: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h00) |->
		(senseData == (deferred_ff ? 8'h73 : 8'h72)))
		else $error("response code wrong");

	a_addl_length: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h07) |-> senseData == 8'h34)
		else $error("additional sense length wrong");

	a_info_head: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h09) |-> senseData == 8'h0a)
		else $error("information descriptor length wrong");

	a_info_valid: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h0a) |-> senseData == {infoValid_ff, 7'h00})
		else $error("information valid bit wrong");

	a_info_lba: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h13 && !mismatch_ff) |-> senseData == lba_ff[7:0])
		else $error("information field is not the LBA");

	a_info_residue: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h0c && mismatch_ff) |->
		senseData == {8{residue_ff[31]}})
		else $error("residue sign extension wrong");

	a_type_order: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h14) |-> senseData == 8'h01)
		else $error("command-specific descriptor misplaced");

	a_keyspec_head: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h21) |-> senseData == 8'h06)
		else $error("key-specific descriptor length wrong");

	a_progress_valid: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h24 && progressMode_ff) |-> senseData == 8'h80)
		else $error("progress not marked valid");

	a_part_code: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h2b) |-> senseData == partCode_ff)
		else $error("replaceable part code wrong");

	a_mismatch_bit: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h2f) |-> senseData == {2'b00, mismatch_ff, 5'h00})
		else $error("mismatch flag misplaced");

	a_unit_error: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h32) |-> senseData == unitErr_ff[15:8])
		else $error("unit error code wrong");

	a_phys_head: assert property (@(posedge clock) disable iff (!rst_b)
		(senseValid && senseIndex == 6'h34) |-> senseData == 8'h81)
		else $error("physical record descriptor type wrong");

endmodule // dsb_sense_builder

// file: hdl/dsb_pkg.sv
// Constants, register map and types of the descriptor sense data builder
package dsb_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_KEY      = 8'h04;
	localparam logic [7:0] REG_LBA_LO   = 8'h08;
	localparam logic [7:0] REG_LBA_HI   = 8'h0c;
	localparam logic [7:0] REG_RESIDUE  = 8'h10;
	localparam logic [7:0] REG_CMD_LO   = 8'h14;
	localparam logic [7:0] REG_CMD_HI   = 8'h18;
	localparam logic [7:0] REG_KEYSPEC  = 8'h1c;
	localparam logic [7:0] REG_PROGRESS = 8'h20;
	localparam logic [7:0] REG_PART     = 8'h24;
	localparam logic [7:0] REG_UNITERR  = 8'h28;
	localparam logic [7:0] REG_PHYS_LO  = 8'h2c;
	localparam logic [7:0] REG_PHYS_HI  = 8'h30;
	localparam logic [7:0] REG_ALLOC    = 8'h34;
	localparam logic [7:0] REG_STATUS   = 8'h38;

	// Control register field positions
	localparam int CTRL_START    = 0;
	localparam int CTRL_DEFERRED = 1;
	localparam int CTRL_INFO_VAL = 2;
	localparam int CTRL_MISMATCH = 3;
	localparam int CTRL_PROGRESS = 4;

	// Reset values
	localparam logic [7:0]  ALLOC_RESET = 8'h3c;
	localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

	// Sense data layout
	localparam logic [6:0] SENSE_BYTES    = 7'h3c;
	localparam logic [7:0] ADDL_SENSE_LEN = 8'h34;
	localparam logic [7:0] RESP_CURRENT   = 8'h72;
	localparam logic [7:0] RESP_DEFERRED  = 8'h73;

	// Descriptor start bytes
	localparam logic [5:0] POS_INFO    = 6'h08;
	localparam logic [5:0] POS_CMD     = 6'h14;
	localparam logic [5:0] POS_KEYSPEC = 6'h20;
	localparam logic [5:0] POS_PART    = 6'h28;
	localparam logic [5:0] POS_BLOCK   = 6'h2c;
	localparam logic [5:0] POS_UNITERR = 6'h30;
	localparam logic [5:0] POS_PHYS    = 6'h34;

	// Descriptor type codes and additional lengths
	localparam logic [7:0] TYPE_INFO    = 8'h00;
	localparam logic [7:0] TYPE_CMD     = 8'h01;
	localparam logic [7:0] TYPE_KEYSPEC = 8'h02;
	localparam logic [7:0] TYPE_PART    = 8'h03;
	localparam logic [7:0] TYPE_BLOCK   = 8'h05;
	localparam logic [7:0] TYPE_UNITERR = 8'h80;
	localparam logic [7:0] TYPE_PHYS    = 8'h81;
	localparam logic [7:0] LEN_0A       = 8'h0a;
	localparam logic [7:0] LEN_06       = 8'h06;
	localparam logic [7:0] LEN_02       = 8'h02;
	localparam int         MISMATCH_BIT = 5;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} dsb_state_t;

endpackage

// file: hdl/dsb_fields_if.sv
// Sense fields and byte index passed from the builder to its byte map
`timescale 1ns/1ns
interface dsb_fields_if;
	logic [5:0]  byteIndex;
	logic        responseDeferred;
	logic [3:0]  senseKey;
	logic [7:0]  asc;
	logic [7:0]  ascq;
	logic        infoValid;
	logic [63:0] infoField;
	logic [63:0] cmdSpecific;
	logic        keySpecificValid;
	logic [6:0]  keySpecificBits;
	logic [15:0] keySpecificBytes;
	logic [7:0]  replaceablePartCode;
	logic        lengthMismatchFlag;
	logic [15:0] unitErrorCode;
	logic [47:0] physRecord;
	logic [7:0]  byteOut;

	modport src (
		output byteIndex, responseDeferred, senseKey, asc, ascq, infoValid, infoField,
		output cmdSpecific, keySpecificValid, keySpecificBits, keySpecificBytes,
		output replaceablePartCode, lengthMismatchFlag, unitErrorCode, physRecord,
		input  byteOut
	);
	modport map (
		input  byteIndex, responseDeferred, senseKey, asc, ascq, infoValid, infoField,
		input  cmdSpecific, keySpecificValid, keySpecificBits, keySpecificBytes,
		input  replaceablePartCode, lengthMismatchFlag, unitErrorCode, physRecord,
		output byteOut
	);
endinterface

// file: hdl/dsb_byte_map.sv
// Byte map: value of each descriptor-format sense byte by its index
`timescale 1ns/1ns
module dsb_byte_map (
	dsb_fields_if.map f
);

	// Byte k of a big-endian field, k counted from the least significant byte
	function automatic logic [7:0] pickByte(input logic [63:0] v, input logic [5:0] k);
		pickByte = v[{k[2:0], 3'b000} +: 8];
	endfunction

	logic [5:0] idx;
	assign idx = f.byteIndex;

	// Order of descriptors is fixed; absent content still occupies its bytes
	always_comb begin
		f.byteOut = 8'h00;
		unique case (idx)
			6'h00: f.byteOut = f.responseDeferred ? dsb_pkg::RESP_DEFERRED
			                                      : dsb_pkg::RESP_CURRENT;
			6'h01: f.byteOut = {4'h0, f.senseKey};
			6'h02: f.byteOut = f.asc;
			6'h03: f.byteOut = f.ascq;
			6'h07: f.byteOut = dsb_pkg::ADDL_SENSE_LEN;
			6'h08: f.byteOut = dsb_pkg::TYPE_INFO;
			6'h09: f.byteOut = dsb_pkg::LEN_0A;
			6'h0a: f.byteOut = {f.infoValid, 7'h00};
			6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13:
				f.byteOut = pickByte(f.infoField, 6'h13 - idx);
			6'h14: f.byteOut = dsb_pkg::TYPE_CMD;
			6'h15: f.byteOut = dsb_pkg::LEN_0A;
			6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f:
				f.byteOut = pickByte(f.cmdSpecific, 6'h1f - idx);
			6'h20: f.byteOut = dsb_pkg::TYPE_KEYSPEC;
			6'h21: f.byteOut = dsb_pkg::LEN_06;
			6'h24: f.byteOut = {f.keySpecificValid, f.keySpecificBits};
			6'h25: f.byteOut = f.keySpecificBytes[15:8];
			6'h26: f.byteOut = f.keySpecificBytes[7:0];
			6'h28: f.byteOut = dsb_pkg::TYPE_PART;
			6'h29: f.byteOut = dsb_pkg::LEN_02;
			6'h2b: f.byteOut = f.replaceablePartCode;
			6'h2c: f.byteOut = dsb_pkg::TYPE_BLOCK;
			6'h2d: f.byteOut = dsb_pkg::LEN_02;
			6'h2f: f.byteOut = {2'b00, f.lengthMismatchFlag, 5'h00};
			6'h30: f.byteOut = dsb_pkg::TYPE_UNITERR;
			6'h31: f.byteOut = dsb_pkg::LEN_02;
			6'h32: f.byteOut = f.unitErrorCode[15:8];
			6'h33: f.byteOut = f.unitErrorCode[7:0];
			6'h34: f.byteOut = dsb_pkg::TYPE_PHYS;
			6'h35: f.byteOut = dsb_pkg::LEN_06;
			6'h36, 6'h37, 6'h38, 6'h39, 6'h3a, 6'h3b:
				f.byteOut = pickByte({16'h0000, f.physRecord}, 6'h3b - idx);
			default: f.byteOut = 8'h00;
		endcase
	end

endmodule // dsb_byte_map

// file: verification/dsb_host_sink.sv
// Host initiator model that takes sense bytes, promptly or with stalls
`timescale 1ns/1ns
module dsb_host_sink (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       slow,
	input  wire logic       senseValid,
	input  wire logic [7:0] senseData,
	input  wire logic [5:0] senseIndex,
	input  wire logic       senseLast,
	output logic            senseReady
);
	logic [15:0] q[$];
	logic [2:0]  stallCnt;
	always @(posedge clock) begin
		if (!rst_b) begin
			senseReady <= 1'b0;
			stallCnt   <= 3'h0;
		end else begin
			stallCnt   <= stallCnt + 3'h1;
			// Slow host takes bytes on three cycles in eight only
			senseReady <= !slow || (stallCnt < 3'h3);
			if (senseValid && senseReady)
				q.push_back({senseLast, 1'b0, senseIndex, senseData});
		end
	end
endmodule // dsb_host_sink

// file: verification/tb_top.sv
// Self-checking bench for the descriptor sense data builder
`timescale 1ns/1ns
module tb_top;
	logic        clock, rst_b, hsel, hwrite, hready, hreadyout, hresp, slow;
	logic        senseValid, senseReady, senseLast;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  senseData, alloc;
	logic [5:0]  senseIndex;
	logic [63:0] info;
	logic [23:0] ksb;
	logic [479:0] img;
	logic [31:0] regV [12];
	logic [7:0]  regA [12];
	logic [7:0]  allocTab [7];
	logic [31:0] ctl;
	logic [15:0] b;
	int          n_errors, checked, n, m;

	assign hready = hreadyout;

	dsb_sense_builder dut_u (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .senseValid(senseValid),
		.senseReady(senseReady), .senseData(senseData), .senseIndex(senseIndex),
		.senseLast(senseLast));
	dsb_host_sink sink_u (.clock(clock), .rst_b(rst_b), .slow(slow), .senseValid(senseValid),
		.senseData(senseData), .senseIndex(senseIndex), .senseLast(senseLast),
		.senseReady(senseReady));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= 3'b010;
		k = 0;
		do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_errors++;
			print_verdict();
		end
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		k = 0;
		do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 20);
		r = hrdata;
		if (k >= 20) begin
			n_errors++;
			print_verdict();
		end
	endtask

	initial begin
		seed = 32'd6175;
		n_errors = 0;
		checked = 0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		slow = 1'b0;
		regA = '{dsb_pkg::REG_KEY, dsb_pkg::REG_LBA_LO, dsb_pkg::REG_LBA_HI,
			dsb_pkg::REG_RESIDUE, dsb_pkg::REG_CMD_LO, dsb_pkg::REG_CMD_HI,
			dsb_pkg::REG_KEYSPEC, dsb_pkg::REG_PROGRESS, dsb_pkg::REG_PART,
			dsb_pkg::REG_UNITERR, dsb_pkg::REG_PHYS_LO, dsb_pkg::REG_PHYS_HI};
		allocTab = '{8'h3c, 8'hff, 8'h01, 8'h14, 8'h00, 8'h3b, 8'h08};
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		bus(1'b0, dsb_pkg::REG_ALLOC, 32'h0, rd);
		chk("alloc reset", 32'h3c, rd);
		bus(1'b1, 8'h3c, 32'hffff_ffff, rd);
		bus(1'b0, 8'h3c, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		for (int f = 0; f < 7; f++) begin
			slow <= f[0];
			alloc = allocTab[f];
			n = (alloc < 60) ? alloc : 60;
			for (int i = 0; i < 12; i++) begin
				regV[i] = rnd();
				bus(1'b1, regA[i], regV[i], rd);
			end
			ctl = (rnd() & 32'h1e) | 32'h1;
			info = ctl[3] ? {{32{regV[3][31]}}, regV[3]} : {regV[2], regV[1]};
			ksb = ctl[4] ? {8'h80, regV[7][15:0]} : regV[6][23:0];
			img = {ctl[1] ? 8'h73 : 8'h72, 4'h0, regV[0][3:0], regV[0][15:8],
				regV[0][23:16], 24'h0, 8'h34, 16'h000a, ctl[2], 15'h0, info,
				16'h010a, 16'h0, regV[5], regV[4], 16'h0206, 16'h0, ksb, 8'h0,
				16'h0302, 8'h0, regV[8][7:0], 16'h0502, 8'h0, 2'h0, ctl[3], 5'h0,
				16'h8002, regV[9][15:0], 16'h8106, regV[11][15:0], regV[10]};
			bus(1'b1, dsb_pkg::REG_ALLOC, {24'h0, alloc}, rd);
			bus(1'b1, dsb_pkg::REG_CTRL, ctl, rd);
			if (n >= 20) begin
				// Write during a frame must leave the limit untouched
				bus(1'b1, dsb_pkg::REG_ALLOC, 32'h0, rd);
				bus(1'b0, dsb_pkg::REG_STATUS, 32'h0, rd);
				chk("busy", 32'h1, {31'h0, rd[0]});
			end
			m = 0;
			do begin
				bus(1'b0, dsb_pkg::REG_STATUS, 32'h0, rd);
				m++;
			end while (rd[0] !== 1'b0 && m < 400);
			if (m >= 400) begin
				n_errors++;
				print_verdict();
			end
			chk("accepted", n, {25'h0, rd[14:8]});
			chk("count", n, sink_u.q.size());
			for (int i = 0; i < n; i++) begin
				b = sink_u.q.pop_front();
				chk("byte", img[479 - 8 * i -: 8], b[7:0]);
				chk("index", i, b[13:8]);
				chk("last", (i == n - 1), b[15]);
			end
			sink_u.q.delete();
			chk("idle", 32'h0, {31'h0, senseValid});
			bus(1'b0, dsb_pkg::REG_ALLOC, 32'h0, rd);
			chk("alloc kept", alloc, rd);
		end
		print_verdict();
	end
endmodule // tb_top
